// File: sccd_clock_ctrl.sv
`timescale 1ns/1ps
module sccd_clock_ctrl (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register access port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // oscillator sources and their stop controls
  input wire logic main_osc_in,
  input wire logic sub_osc_clock_in,
  output logic main_osc_stop_out,
  output logic sub_osc_stop_out,
  // power-down requests and wake sources
  input wire logic idle_req_in,
  input wire logic stop_req_in,
  input wire logic ext_irq_in,
  input wire logic int_irq_in,
  input wire logic watch_on_sub_in,
  // clock enables and status
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic stop_reset_out,
  output sccd_pkg::sccd_state_e power_state_out
);
  import sccd_pkg::*;

  // terminal count for a divider code
  function automatic logic [3:0] div_limit(input logic [1:0] code);
    case (code)
      SCCD_DIV16: div_limit = SCCD_TC16;
      SCCD_DIV8: div_limit = SCCD_TC8;
      SCCD_DIV2: div_limit = SCCD_TC2;
      default: div_limit = SCCD_TC1;
    endcase
  endfunction

  // synchronisers: main, sub, external irq (stage 1 then stage 2)
  logic [2:0] sync1_reg, sync1_next;
  logic [2:0] sync2_reg, sync2_next;
  // previous stage-2 oscillator levels for edge detection
  logic [1:0] osc_prev_reg, osc_prev_next;
  // software registers
  logic div_wake_reg, div_wake_next; // wake selection bit, stored only
  logic [1:0] div_code_reg, div_code_next;
  logic src_sel_reg, src_sel_next;
  logic main_stop_reg, main_stop_next;
  logic sub_stop_reg, sub_stop_next;
  logic [7:0] key_reg, key_next;
  // divider state and ratio/source in effect
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] act_div_reg, act_div_next;
  logic act_sel_reg, act_sel_next;
  sccd_state_e state_reg, state_next;
  // registered outputs
  logic [7:0] rdata_reg, rdata_next;
  logic cpu_en_reg, cpu_en_next;
  logic per_en_reg, per_en_next;
  logic srst_reg, srst_next;
  logic main_halt_reg, main_halt_next;
  // decoded ticks
  logic main_tick, sub_tick, sel_tick, wrap, ext_wake, int_wake;

  // sync and edge next values
  always_comb begin
    sync1_next = {ext_irq_in, sub_osc_clock_in, main_osc_in};
    sync2_next = sync1_reg;
    osc_prev_next = sync2_reg[1:0];
  end

  // synchroniser and edge registers
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      osc_prev_reg <= 2'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      osc_prev_reg <= osc_prev_next;
    end
  end

  // rising edges of each source and of the selected one
  // source picks ticks
  assign main_tick = sync2_reg[0] & ~osc_prev_reg[0];
  assign sub_tick = sync2_reg[1] & ~osc_prev_reg[1];
  assign sel_tick = act_sel_reg ? sub_tick : main_tick;
  assign wrap = sel_tick && (cnt_reg == div_limit(act_div_reg));
  assign ext_wake = sync2_reg[2];
  assign int_wake = int_irq_in && !sub_stop_reg && watch_on_sub_in;

  // register file next values
  always_comb begin
    div_wake_next = div_wake_reg;
    div_code_next = div_code_reg;
    src_sel_next = src_sel_reg;
    main_stop_next = main_stop_reg;
    sub_stop_next = sub_stop_reg;
    key_next = key_reg;
    rdata_next = rdata_reg;
    if (reg_wr_in) begin
      case (reg_addr_in)
        SCCD_ADDR_CLKDIV: begin
          div_wake_next = reg_wdata_in[SCCD_WAKE_BIT];
          div_code_next = reg_wdata_in[SCCD_DIV_MSB:SCCD_DIV_LSB];
        end
        SCCD_ADDR_OSCSRC: begin
          src_sel_next = reg_wdata_in[SCCD_SRC_BIT];
          main_stop_next = reg_wdata_in[SCCD_MAIN_STOP_BIT];
          sub_stop_next = reg_wdata_in[SCCD_SUB_STOP_BIT];
        end
        SCCD_ADDR_STPKEY: key_next = reg_wdata_in;
        default: ; // unmapped writes ignored
      endcase
    end
    if (reg_rd_in) begin
      rdata_next = SCCD_READ_ZERO;
      case (reg_addr_in)
        SCCD_ADDR_CLKDIV: begin
          rdata_next[SCCD_WAKE_BIT] = div_wake_reg;
          rdata_next[SCCD_DIV_MSB:SCCD_DIV_LSB] = div_code_reg;
        end
        SCCD_ADDR_OSCSRC: begin
          rdata_next[SCCD_SRC_BIT] = src_sel_reg;
          rdata_next[SCCD_MAIN_STOP_BIT] = main_stop_reg;
          rdata_next[SCCD_SUB_STOP_BIT] = sub_stop_reg;
        end
        SCCD_ADDR_STPKEY: rdata_next = key_reg;
        default: ; // unmapped reads give zero
      endcase
    end
  end

  // register file storage
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      div_wake_reg <= 1'h0;
      div_code_reg <= SCCD_DIV_RESET;
      src_sel_reg <= 1'h0;
      main_stop_reg <= 1'h0;
      sub_stop_reg <= 1'h0;
      key_reg <= SCCD_KEY_RESET;
      rdata_reg <= SCCD_READ_ZERO;
    end else begin
      div_wake_reg <= div_wake_next;
      div_code_reg <= div_code_next;
      src_sel_reg <= src_sel_next;
      main_stop_reg <= main_stop_next;
      sub_stop_reg <= sub_stop_next;
      key_reg <= key_next;
      rdata_reg <= rdata_next;
    end
  end

  // divider and power state next values
  always_comb begin
    cnt_next = cnt_reg;
    act_div_next = act_div_reg;
    act_sel_next = act_sel_reg;
    state_next = state_reg;
    srst_next = 1'h0;
    if (sel_tick) begin
      cnt_next = wrap ? SCCD_TC1 : cnt_reg + SCCD_CNT_ONE;
    end
    if (wrap) begin
      act_div_next = div_code_reg;
      act_sel_next = src_sel_reg;
    end
    case (state_reg)
      SCCD_RUN: begin
        if (stop_req_in) begin
          if (key_reg == SCCD_STOP_KEY) state_next = SCCD_STOP;
          else srst_next = 1'h1;
        end else if (idle_req_in) begin
          state_next = SCCD_IDLE;
        end
      end
      SCCD_IDLE: if (ext_wake || int_irq_in) state_next = SCCD_RUN;
      SCCD_STOP: if (ext_wake || int_wake) state_next = SCCD_RUN;
      default: state_next = SCCD_RUN;
    endcase
    cpu_en_next = wrap && (state_reg == SCCD_RUN);
    per_en_next = sel_tick;
    main_halt_next = main_stop_reg || (state_next == SCCD_STOP);
  end

  // divider, state and output registers
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cnt_reg <= SCCD_TC1;
      act_div_reg <= SCCD_DIV_RESET;
      act_sel_reg <= 1'h0;
      state_reg <= SCCD_RUN;
      cpu_en_reg <= 1'h0;
      per_en_reg <= 1'h0;
      srst_reg <= 1'h0;
      main_halt_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      act_div_reg <= act_div_next;
      act_sel_reg <= act_sel_next;
      state_reg <= state_next;
      cpu_en_reg <= cpu_en_next;
      per_en_reg <= per_en_next;
      srst_reg <= srst_next;
      main_halt_reg <= main_halt_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_out = rdata_reg;
  assign main_osc_stop_out = main_halt_reg;
  assign sub_osc_stop_out = sub_stop_reg;
  assign cpu_clk_en_out = cpu_en_reg;
  assign periph_clk_en_out = per_en_reg;
  assign stop_reset_out = srst_reg;
  assign power_state_out = state_reg;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_div_reset_slow: assert property ($rose(reset_n_in) |-> div_code_reg == SCCD_DIV16)
    else $error("divider code not slowest after reset");
  a_div_wrap_ratio: assert property (sel_tick && cnt_reg == div_limit(act_div_reg) |=> cnt_reg == SCCD_TC1)
    else $error("divider did not wrap at terminal count");
  a_div_count_up: assert property (sel_tick && !wrap |=> cnt_reg == $past(cnt_reg) + SCCD_CNT_ONE)
    else $error("divider did not advance on a tick");
  a_ratio_hold: assert property (!wrap |=> act_div_reg == $past(act_div_reg))
    else $error("ratio changed away from a boundary");
  a_src_tick_follow: assert property (##1 periph_clk_en_out == $past(act_sel_reg ? sub_tick : main_tick))
    else $error("peripheral tick not from selected source");
  a_idle_cpu_gate: assert property (state_reg == SCCD_IDLE |=> !cpu_clk_en_out)
    else $error("cpu clocked during idle");
  a_stop_main_halt: assert property (state_reg == SCCD_STOP |-> main_osc_stop_out)
    else $error("main oscillator running in stop");
  a_stop_good_key: assert property (state_reg == SCCD_RUN && stop_req_in && key_reg == SCCD_STOP_KEY
    |=> state_reg == SCCD_STOP && !stop_reset_out)
    else $error("stop with key not entered");
  a_stop_bad_key: assert property (state_reg == SCCD_RUN && stop_req_in && key_reg != SCCD_STOP_KEY
    |=> stop_reset_out ##1 !stop_reset_out)
    else $error("bad key did not give one reset pulse");
  a_stop_ext_wake: assert property (state_reg == SCCD_STOP && ext_wake |=> state_reg == SCCD_RUN)
    else $error("external interrupt did not end stop");
  a_stop_int_block: assert property (state_reg == SCCD_STOP && !ext_wake && (sub_stop_reg || !watch_on_sub_in)
    |=> state_reg == SCCD_STOP)
    else $error("stop left without a valid wake");
  a_idle_wake_any: assert property (state_reg == SCCD_IDLE && (ext_wake || int_irq_in) |=> state_reg == SCCD_RUN)
    else $error("interrupt did not end idle");
  a_osc_stop_bits: assert property (reg_wr_in && reg_addr_in == SCCD_ADDR_OSCSRC
    |=> sub_osc_stop_out == $past(reg_wdata_in[SCCD_SUB_STOP_BIT]))
    else $error("sub oscillator stop not following control");

  c_enter_stop: cover property (state_reg == SCCD_RUN ##1 state_reg == SCCD_STOP);
  c_enter_idle: cover property (state_reg == SCCD_RUN ##1 state_reg == SCCD_IDLE);
  c_bad_key: cover property (stop_reset_out);
  c_sub_undivided: cover property (act_sel_reg && act_div_reg == SCCD_DIV1 && cpu_clk_en_out);
endmodule // sccd_clock_ctrl

// File: sccd_osc_model.sv
`timescale 1ns/1ps
// oscillator source, free running unless told to halt
module sccd_osc_model #(
  parameter int HALF_NS = 33
) (
  input wire logic stop_in,
  output logic osc_out
);
  // halt on stop
  // a halted oscillator gives no edges and sits low
  initial begin
    osc_out = 1'h0;
    forever begin
      #(HALF_NS);
      osc_out = stop_in ? 1'h0 : ~osc_out;
    end
  end
endmodule // sccd_osc_model

// File: sccd_pkg.sv
// Notes on behaviour
// - two sources, selected one clocks CPU and peripherals
// - CPU clock divided by 1, 2, 8 or 16
// - divider code 00=/16, 01=/8, 10=/2, 11=/1
// - divider code resets to 00, slowest ratio
// - stop mode halts the main oscillator
// - reset or external interrupt ends stop mode
// - internal interrupt wakes stop only with subclock watch
// - idle withholds clock from CPU only
// - idle ends on reset or any interrupt
// - source select bit: 0 main, 1 subclock
// - oscillator stop bits 3 main, 2 sub, reset run
package sccd_pkg;
  // register addresses in register addressing space
  localparam logic [7:0] SCCD_ADDR_CLKDIV = 8'hD4;
  localparam logic [7:0] SCCD_ADDR_OSCSRC = 8'hFA;
  localparam logic [7:0] SCCD_ADDR_STPKEY = 8'hED;
  // divide control field positions
  localparam int SCCD_DIV_LSB = 3;
  localparam int SCCD_DIV_MSB = 4;
  localparam int SCCD_WAKE_BIT = 7;
  // oscillator control field positions
  localparam int SCCD_SRC_BIT = 0;
  localparam int SCCD_SUB_STOP_BIT = 2;
  localparam int SCCD_MAIN_STOP_BIT = 3;
  // reset values
  localparam logic [1:0] SCCD_DIV_RESET = 2'h0;
  localparam logic [7:0] SCCD_KEY_RESET = 8'h00;
  localparam logic [7:0] SCCD_READ_ZERO = 8'h00;
  // stop enable key value
  localparam logic [7:0] SCCD_STOP_KEY = 8'hA5;
  // divider codes
  localparam logic [1:0] SCCD_DIV16 = 2'h0;
  localparam logic [1:0] SCCD_DIV8 = 2'h1;
  localparam logic [1:0] SCCD_DIV2 = 2'h2;
  localparam logic [1:0] SCCD_DIV1 = 2'h3;
  // terminal counts per ratio (ratio minus one)
  localparam logic [3:0] SCCD_TC16 = 4'hF;
  localparam logic [3:0] SCCD_TC8 = 4'h7;
  localparam logic [3:0] SCCD_TC2 = 4'h1;
  localparam logic [3:0] SCCD_TC1 = 4'h0;
  localparam logic [3:0] SCCD_CNT_ONE = 4'h1;
  // power states, one-hot
  typedef enum logic [2:0] {
    SCCD_RUN = 3'h1,
    SCCD_IDLE = 3'h2,
    SCCD_STOP = 3'h4
  } sccd_state_e;
endpackage

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sccd_pkg::*;
  logic sys_clk_in, reset_n_in, reg_wr_in, reg_rd_in, main_osc, sub_osc, main_stop, sub_stop;
  logic idle_req_in, stop_req_in, ext_irq_in, int_irq_in, watch_on_sub_in, cpu_en, periph_en, stop_rst;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d;
  sccd_state_e power_state;
  int num_errors = 0, total_checks = 0, seed = 3649, n;
  logic [7:0] exp_q[$];
  logic rd_taken = 1'h0;
  logic [7:0] addrs[4] = '{8'hED, 8'hD4, 8'h33, 8'hFA};
  logic [7:0] masks[4] = '{8'hFF, 8'h98, 8'h00, 8'h0D};
  int ratios[4] = '{16, 8, 2, 1};
  sccd_clock_ctrl DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .main_osc_in(main_osc), .sub_osc_clock_in(sub_osc), .main_osc_stop_out(main_stop),
    .sub_osc_stop_out(sub_stop), .idle_req_in(idle_req_in), .stop_req_in(stop_req_in), .ext_irq_in(ext_irq_in),
    .int_irq_in(int_irq_in), .watch_on_sub_in(watch_on_sub_in), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(periph_en), .stop_reset_out(stop_rst), .power_state_out(power_state));
  // main and sub sources, unrelated to the system clock
  sccd_osc_model #(.HALF_NS(33)) main_src (.stop_in(main_stop), .osc_out(main_osc));
  sccd_osc_model #(.HALF_NS(47)) sub_src (.stop_in(sub_stop), .osc_out(sub_osc));
  initial begin
    sys_clk_in = 1'h0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // compare with printed mismatch
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk_in);
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'h1;
    @(negedge sys_clk_in);
    reg_wr_in = 1'h0;
  endtask
  // note the expected byte, then issue the read
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge sys_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    @(negedge sys_clk_in);
    reg_rd_in = 1'h0;
  endtask
  // read data monitor, half a cycle after the read edge
  always @(posedge sys_clk_in) rd_taken <= reg_rd_in;
  always @(negedge sys_clk_in) begin
    if (rd_taken && exp_q.size() > 0)
      check(reg_rdata_out, exp_q.pop_front());
  end
  // one-cycle idle or stop instruction
  task automatic req(input logic s);
    @(negedge sys_clk_in);
    stop_req_in = s;
    idle_req_in = ~s;
    @(negedge sys_clk_in);
    stop_req_in = 1'h0;
    idle_req_in = 1'h0;
  endtask
  task automatic wait_state(input sccd_state_e e);
    int k;
    k = 0;
    while (power_state !== e && k < 30) begin
      @(negedge sys_clk_in);
      k++;
    end
    check({5'h0, power_state}, {5'h0, e});
    if (k >= 30 && power_state !== e) complete_run();
  endtask
  // peripheral ticks between two cpu ticks, after a settling wrap
  task automatic measure(input int ratio);
    int k;
    int cnt;
    k = 0;
    cnt = 0;
    repeat (2) begin
      @(negedge sys_clk_in);
      while (cpu_en !== 1'h1 && k < 500) begin
        @(negedge sys_clk_in);
        k++;
      end
    end
    do begin
      @(negedge sys_clk_in);
      k++;
      if (periph_en === 1'h1) cnt++;
    end while (cpu_en !== 1'h1 && k < 900);
    check(8'(cnt), 8'(ratio));
    if (k >= 900) begin
      num_errors++;
      complete_run();
    end
  endtask
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {idle_req_in, stop_req_in, ext_irq_in, int_irq_in, watch_on_sub_in} = '0;
    repeat (4) @(negedge sys_clk_in);
    reset_n_in = 1'h1;
    reg_rd(SCCD_ADDR_CLKDIV, 8'h00);
    reg_rd(SCCD_ADDR_OSCSRC, 8'h00);
    reg_rd(SCCD_ADDR_STPKEY, SCCD_KEY_RESET);
    measure(16);
    // random bytes, reserved bits and unmapped place read zero
    for (n = 0; n < 4; n++) begin
      d = 8'($random(seed));
      reg_wr(addrs[n], d);
      reg_rd(addrs[n], d & masks[n]);
    end
    reg_wr(SCCD_ADDR_OSCSRC, 8'h00);
    for (n = 0; n < 4; n++) begin
      reg_wr(SCCD_ADDR_CLKDIV, {3'h0, 2'(n), 3'h0});
      measure(ratios[n]);
    end
    // undivided first, then subclock, then halt main
    reg_wr(SCCD_ADDR_CLKDIV, 8'h18);
    reg_wr(SCCD_ADDR_OSCSRC, 8'h01);
    // the switch needs a main tick, so main must still run here
    repeat (20) @(negedge sys_clk_in);
    reg_wr(SCCD_ADDR_OSCSRC, 8'h09);
    @(negedge sys_clk_in);
    check({7'h0, main_stop}, 8'h01);
    measure(1);
    // restart main and let it settle before switching back
    reg_wr(SCCD_ADDR_OSCSRC, 8'h01);
    repeat (20) @(negedge sys_clk_in);
    reg_wr(SCCD_ADDR_OSCSRC, 8'h00);
    // switch back lands on a sub tick, so sub stops only after it
    repeat (20) @(negedge sys_clk_in);
    reg_wr(SCCD_ADDR_OSCSRC, 8'h04);
    check({6'h0, sub_stop, main_stop}, 8'h02);
    reg_wr(SCCD_ADDR_OSCSRC, 8'h00);
    // idle keeps peripherals ticking, cpu silent
    req(1'h0);
    wait_state(SCCD_IDLE);
    d = 8'h00;
    n = 0;
    repeat (100) begin
      @(negedge sys_clk_in);
      if (cpu_en !== 1'h0) d++;
      if (periph_en === 1'h1) n++;
    end
    check(d, 8'h00);
    check(8'(n > 0), 8'h01);
    int_irq_in = 1'h1;
    wait_state(SCCD_RUN);
    int_irq_in = 1'h0;
    // stop without the key raises a reset instead
    reg_wr(SCCD_ADDR_STPKEY, 8'h5A);
    req(1'h1);
    check({stop_rst, 4'h0, power_state}, {1'h1, 4'h0, SCCD_RUN});
    reg_wr(SCCD_ADDR_STPKEY, SCCD_STOP_KEY);
    req(1'h1);
    check({main_stop, 4'h0, power_state}, {1'h1, 4'h0, SCCD_STOP});
    int_irq_in = 1'h1;
    repeat (10) @(negedge sys_clk_in);
    check({5'h0, power_state}, {5'h0, SCCD_STOP});
    watch_on_sub_in = 1'h1;
    wait_state(SCCD_RUN);
    {int_irq_in, watch_on_sub_in} = 2'h0;
    req(1'h1);
    wait_state(SCCD_STOP);
    ext_irq_in = 1'h1;
    wait_state(SCCD_RUN);
    ext_irq_in = 1'h0;
    measure(1);
    // a reset in mid-run ends stop and brings back the slowest ratio
    req(1'h1);
    wait_state(SCCD_STOP);
    reset_n_in = 1'h0;
    repeat (4) @(negedge sys_clk_in);
    reset_n_in = 1'h1;
    check({main_stop, 4'h0, power_state}, {1'h0, 4'h0, SCCD_RUN});
    reg_rd(SCCD_ADDR_CLKDIV, 8'h00);
    repeat (3) @(negedge sys_clk_in);
    complete_run();
  end
endmodule // tb_top
